// File: logic/sfad_clock_table.sv
// Clock count lookup per decoded operation.
// Assumes operation class and mode come from the decoder on the same clock.
`timescale 1ns/1ns
`include "sfad_map.svh"
module sfad_clock_table
  import sfad_pkg::*;
(
  // Decoded operation
  input  wire sfad_pkg::sfad_op_e op_i,
  input  wire logic               mem_dest_i,
  input  wire logic               prot_mode_i,
  // Result
  output      sfad_pkg::sfad_clk_t clocks_o
);
  import sfad_pkg::*;

  always_comb begin
    case (op_i)
      SFAD_LD_DATA, SFAD_LD_EXTRA, SFAD_LD_STACK:
        clocks_o = prot_mode_i ? `SFAD_CLK_SEG_PROT : `SFAD_CLK_SEG_REAL;
      SFAD_LD_THIRD, SFAD_LD_FOURTH:
        clocks_o = prot_mode_i ? `SFAD_CLK_SEGX_PROT : `SFAD_CLK_SEG_REAL;
      SFAD_CARRY_CLR, SFAD_DIR_CLR, SFAD_CARRY_SET, SFAD_DIR_SET, SFAD_CARRY_INV,
      SFAD_FLAGS_TO_AH:
        clocks_o = `SFAD_CLK_FLAG;
      SFAD_INT_CLR, SFAD_INT_SET: clocks_o = `SFAD_CLK_INT;
      SFAD_TS_CLR:                clocks_o = `SFAD_CLK_TS_CLEAR;
      SFAD_AH_TO_FLAGS:           clocks_o = `SFAD_CLK_AH_FLAGS;
      SFAD_ADD_IMM, SFAD_ADC_IMM:
        clocks_o = mem_dest_i ? `SFAD_CLK_MEM7 : `SFAD_CLK_REG;
      SFAD_INC:                   clocks_o = mem_dest_i ? `SFAD_CLK_MEM6 : `SFAD_CLK_REG;
      SFAD_ACC_ADD, SFAD_SUB_REG: clocks_o = `SFAD_CLK_REG;
      SFAD_ADD_MEM:               clocks_o = `SFAD_CLK_MEM6;
      SFAD_ADC_TOMEM:             clocks_o = `SFAD_CLK_MEM7;
      default:                    clocks_o = 6'h00;
    endcase
  end
endmodule : sfad_clock_table

// File: logic/sfad_cycle_timer.sv
// Down counter that holds busy for a loaded number of clocks.
// Assumes load only when idle; ce freezes it.
`timescale 1ns/1ns
module sfad_cycle_timer
  import sfad_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               resetn_i,
  input  wire logic               ce_i,
  // Control
  input  wire logic               load_i,
  input  wire sfad_pkg::sfad_clk_t count_i,
  // Status
  output      logic               busy_o,
  output      logic               last_o
);
  import sfad_pkg::*;

  sfad_clk_t cnt_reg;
  sfad_clk_t cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = count_i;
    end else if (cnt_reg != 6'h00) begin
      cnt_next = cnt_reg - 6'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 6'h00;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy_o = (cnt_reg != 6'h00);
  assign last_o = (cnt_reg == 6'h01);
endmodule : sfad_cycle_timer

// File: logic/sfad_decoder.sv
// Decoder for segment pointer loads, flag control and early add group.
// Assumes opcode bytes arrive one per valid cycle from same-clock fetch logic.
`timescale 1ns/1ns
`include "sfad_map.svh"
module sfad_decoder
  import sfad_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                resetn_i,
  input  wire logic                ce_i,
  // Mode
  input  wire logic                prot_mode_i,
  // Byte stream
  input  wire logic                byte_valid_i,
  input  wire logic [7:0]          byte_i,
  output      logic                byte_ready_o,
  // Decoded operation
  output      logic                op_start_o,
  output      sfad_pkg::sfad_op_e  op_o,
  output      logic                op_wide_o,
  output      logic                op_mem_o,
  output      sfad_pkg::sfad_clk_t op_clocks_o,
  output      logic                busy_o,
  output      logic                done_o,
  output      logic                unknown_o
);
  import sfad_pkg::*;

  typedef enum logic [1:0] {ST_FIRST, ST_ESCAPE, ST_MODRM, ST_EXEC} sfad_state_e;

  // ==========================================================
  // Helpers
  function automatic logic is_mem(input logic [7:0] modrm);
    is_mem = (modrm[7:6] != `SFAD_MOD_REG);
  endfunction : is_mem

  // All four forms 80..83: sign-extend and width bits sit below the prefix
  function automatic logic is_imm_group(input logic [7:0] op);
    is_imm_group = (op[7:2] == `SFAD_OP6_IMM_GROUP);
  endfunction : is_imm_group

  // ==========================================================
  // State
  sfad_state_e state_reg, state_next;
  sfad_op_e    op_reg, op_next;
  logic [7:0]  first_reg, first_next;
  logic        wide_reg, wide_next;
  logic        mem_reg, mem_next;
  logic        unknown_reg, unknown_next;
  sfad_clk_t   clocks_reg, clocks_next;
  logic        start_reg, start_next;
  sfad_clk_t   table_clocks;
  sfad_op_e    table_op;
  logic        table_mem;
  logic        load;
  logic        tmr_busy;
  logic        tmr_last;
  logic        take;

  assign take = byte_valid_i && byte_ready_o;
  assign byte_ready_o = (state_reg != ST_EXEC);

  always_comb begin
    state_next   = state_reg;
    op_next      = op_reg;
    first_next   = first_reg;
    wide_next    = wide_reg;
    mem_next     = mem_reg;
    unknown_next = 1'b0;
    clocks_next  = clocks_reg;
    start_next   = 1'b0;
    load         = 1'b0;
    table_op     = SFAD_NONE;
    table_mem    = 1'b0;
    case (state_reg)
      ST_FIRST: begin
        if (take) begin
          first_next = byte_i;
          wide_next  = byte_i[0];
          mem_next   = 1'b0;
          if (byte_i == `SFAD_OP_ESCAPE) begin
            state_next = ST_ESCAPE;
          end else if (byte_i == `SFAD_OP_LD_DATA) begin
            op_next = SFAD_LD_DATA;
            state_next = ST_MODRM;
          end else if (byte_i == `SFAD_OP_LD_EXTRA) begin
            op_next = SFAD_LD_EXTRA;
            state_next = ST_MODRM;
          end else if (is_imm_group(byte_i) || byte_i[7:1] == `SFAD_OP7_INC_GROUP
                       || byte_i[7:1] == `SFAD_OP7_ADD_MEM || byte_i[7:1] == `SFAD_OP7_ADC_TOMEM
                       || byte_i[7:2] == `SFAD_OP6_SUB_REG) begin
            op_next = SFAD_NONE;
            state_next = ST_MODRM;
          end else begin
            if (byte_i == `SFAD_OP_CARRY_CLR) table_op = SFAD_CARRY_CLR;
            else if (byte_i == `SFAD_OP_DIR_CLR) table_op = SFAD_DIR_CLR;
            else if (byte_i == `SFAD_OP_INT_CLR) table_op = SFAD_INT_CLR;
            else if (byte_i == `SFAD_OP_CARRY_INV) table_op = SFAD_CARRY_INV;
            else if (byte_i == `SFAD_OP_FLAGS_TO_AH) table_op = SFAD_FLAGS_TO_AH;
            else if (byte_i == `SFAD_OP_AH_TO_FLAGS) table_op = SFAD_AH_TO_FLAGS;
            else if (byte_i == `SFAD_OP_CARRY_SET) table_op = SFAD_CARRY_SET;
            else if (byte_i == `SFAD_OP_DIR_SET) table_op = SFAD_DIR_SET;
            else if (byte_i == `SFAD_OP_INT_SET) table_op = SFAD_INT_SET;
            else if (byte_i[7:1] == `SFAD_OP7_ACC_ADD) table_op = SFAD_ACC_ADD;
            if (table_op == SFAD_NONE) begin
              unknown_next = 1'b1;
            end else begin
              op_next = table_op;
              load = 1'b1;
              clocks_next = table_clocks;
              start_next = 1'b1;
              state_next = ST_EXEC;
            end
          end
        end
      end
      ST_ESCAPE: begin
        if (take) begin
          if (byte_i == `SFAD_OP2_LD_THIRD) begin
            op_next = SFAD_LD_THIRD;
            state_next = ST_MODRM;
          end else if (byte_i == `SFAD_OP2_LD_FOURTH) begin
            op_next = SFAD_LD_FOURTH;
            state_next = ST_MODRM;
          end else if (byte_i == `SFAD_OP2_LD_STACK) begin
            op_next = SFAD_LD_STACK;
            state_next = ST_MODRM;
          end else if (byte_i == `SFAD_OP2_TS_CLEAR) begin
            table_op = SFAD_TS_CLR;
            op_next = table_op;
            load = 1'b1;
            clocks_next = table_clocks;
            start_next = 1'b1;
            state_next = ST_EXEC;
          end else begin
            unknown_next = 1'b1;
            state_next = ST_FIRST;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          table_mem = is_mem(byte_i);
          table_op = op_reg;
          if (op_reg == SFAD_NONE) begin
            if (is_imm_group(first_reg) && byte_i[5:3] == `SFAD_FLD_ADD) begin
              table_op = SFAD_ADD_IMM;
            end else if (is_imm_group(first_reg) && byte_i[5:3] == `SFAD_FLD_ADC) begin
              table_op = SFAD_ADC_IMM;
            end else if (first_reg[7:1] == `SFAD_OP7_INC_GROUP && byte_i[5:3] == `SFAD_FLD_INC) begin
              table_op = SFAD_INC;
            end else if (first_reg[7:1] == `SFAD_OP7_ADD_MEM) begin
              table_op = SFAD_ADD_MEM;
            end else if (first_reg[7:2] == `SFAD_OP6_SUB_REG) begin
              table_op = SFAD_SUB_REG;
            end else if (first_reg[7:1] == `SFAD_OP7_ADC_TOMEM) begin
              table_op = SFAD_ADC_TOMEM;
            end
          end
          if (table_op == SFAD_NONE) begin
            // Other group members belong to a different decoder slice
            unknown_next = 1'b1;
            state_next = ST_FIRST;
          end else begin
            op_next = table_op;
            mem_next = table_mem;
            load = 1'b1;
            clocks_next = table_clocks;
            start_next = 1'b1;
            state_next = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        // Last count cycle frees the byte port on the next edge
        if (tmr_last) begin
          state_next = ST_FIRST;
        end
      end
      default: state_next = ST_FIRST;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg   <= ST_FIRST;
      op_reg      <= SFAD_NONE;
      first_reg   <= 8'h00;
      wide_reg    <= 1'b0;
      mem_reg     <= 1'b0;
      unknown_reg <= 1'b0;
      clocks_reg  <= 6'h00;
      start_reg   <= 1'b0;
    end else if (ce_i) begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      first_reg   <= first_next;
      wide_reg    <= wide_next;
      mem_reg     <= mem_next;
      unknown_reg <= unknown_next;
      clocks_reg  <= clocks_next;
      start_reg   <= start_next;
    end
  end

  // ==========================================================
  // Count lookup and timer
  sfad_clock_table u_table (
    .op_i        (table_op),
    .mem_dest_i  (table_mem),
    .prot_mode_i (prot_mode_i),
    .clocks_o    (table_clocks)
  );

  sfad_cycle_timer u_timer (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .load_i    (load),
    .count_i   (table_clocks),
    .busy_o    (tmr_busy),
    .last_o    (tmr_last)
  );

  assign op_start_o  = start_reg;
  assign op_o        = op_reg;
  assign op_wide_o   = wide_reg;
  assign op_mem_o    = mem_reg;
  assign op_clocks_o = clocks_reg;
  assign busy_o      = tmr_busy;
  assign done_o      = tmr_last && ce_i;
  assign unknown_o   = unknown_reg;
endmodule : sfad_decoder

// File: shared/sfad_map.svh
// Function
// - First byte 0xc5 with addressing byte loads data segment slot; 7 or 22 clocks.
// - First byte 0xc4 with addressing byte loads extra segment slot; 7 or 22 clocks.
// - Escape then 0xb4 loads third segment slot; 7 or 25 clocks.
// - Escape then 0xb5 loads fourth segment slot; 7 or 25 clocks.
// - Escape then 0xb2 loads stack segment slot; 7 or 22 clocks.
// - Carry clear takes 2 clocks in every mode.
// - Direction clear takes 2 clocks in every mode.
// - Interrupt enable clear takes 8 clocks in every mode.
// - Escape then 0x06 clears task-switched flag in 6 clocks.
// - Byte 0xf5 inverts carry in 2 clocks.
// - Byte 0x9f moves flags into accumulator high byte in 2 clocks.
// - Byte 0x9e copies accumulator high byte into flags in 3 clocks.
// - Carry set takes 2 clocks in every mode.
// - Direction set takes 2 clocks in every mode.
// - Interrupt enable set takes 8 clocks in every mode.
// - Immediate group field 000 is add immediate; 2 register, 7 memory.
// - Immediate group field 010 is add-with-carry immediate; 2 register, 7 memory.
// - Accumulator add immediate 0000010w takes 2 clocks.
// - Opcode 1111111w field 000 increments; 2 register, 6 memory.
// - Add memory to register 0000001w takes 6 clocks.
// - Register subtract 001010dw takes 2 clocks.
// - Add-with-carry register to memory 0001000w takes 7 clocks.
//
// Opcode values and clock counts for the segment-load, flag and add decoder.
// Assumes it is included by the package and the logic files only.
`ifndef SFAD_MAP_SVH
`define SFAD_MAP_SVH

// ==========================================================
// Opcode bytes
`define SFAD_OP_ESCAPE      8'h0f
`define SFAD_OP_LD_DATA     8'hc5
`define SFAD_OP_LD_EXTRA    8'hc4
`define SFAD_OP2_LD_THIRD   8'hb4
`define SFAD_OP2_LD_FOURTH  8'hb5
`define SFAD_OP2_LD_STACK   8'hb2
`define SFAD_OP2_TS_CLEAR   8'h06
`define SFAD_OP_CARRY_CLR   8'hf8
`define SFAD_OP_CARRY_SET   8'hf9
`define SFAD_OP_INT_CLR     8'hfa
`define SFAD_OP_INT_SET     8'hfb
`define SFAD_OP_DIR_CLR     8'hfc
`define SFAD_OP_DIR_SET     8'hfd
`define SFAD_OP_CARRY_INV   8'hf5
`define SFAD_OP_FLAGS_TO_AH 8'h9f
`define SFAD_OP_AH_TO_FLAGS 8'h9e
// Seven-bit prefixes, lowest bit is the width bit
`define SFAD_OP7_ACC_ADD    7'h02
`define SFAD_OP7_INC_GROUP  7'h7f
`define SFAD_OP7_ADD_MEM    7'h01
`define SFAD_OP7_ADC_TOMEM  7'h08
// Six-bit prefixes: immediate group keeps sign and width below, subtract keeps d and w
`define SFAD_OP6_IMM_GROUP  6'h20
`define SFAD_OP6_SUB_REG    6'h0a
// Operation field values
`define SFAD_FLD_ADD        3'h0
`define SFAD_FLD_ADC        3'h2
`define SFAD_FLD_INC        3'h0
`define SFAD_MOD_REG        2'h3

// ==========================================================
// Clock counts
`define SFAD_CLK_SEG_REAL   6'h07
`define SFAD_CLK_SEG_PROT   6'h16
`define SFAD_CLK_SEGX_PROT  6'h19
`define SFAD_CLK_FLAG       6'h02
`define SFAD_CLK_INT        6'h08
`define SFAD_CLK_TS_CLEAR   6'h06
`define SFAD_CLK_AH_FLAGS   6'h03
`define SFAD_CLK_REG        6'h02
`define SFAD_CLK_MEM7       6'h07
`define SFAD_CLK_MEM6       6'h06

`endif

// File: shared/sfad_pkg.sv
// Types shared by the decoder and its helpers.
// Assumes sfad_map.svh is on the include path.
package sfad_pkg;
  `include "sfad_map.svh"

  typedef enum logic [4:0] {
    SFAD_NONE, SFAD_LD_DATA, SFAD_LD_EXTRA, SFAD_LD_THIRD, SFAD_LD_FOURTH, SFAD_LD_STACK,
    SFAD_CARRY_CLR, SFAD_DIR_CLR, SFAD_INT_CLR, SFAD_TS_CLR, SFAD_CARRY_INV,
    SFAD_FLAGS_TO_AH, SFAD_AH_TO_FLAGS, SFAD_CARRY_SET, SFAD_DIR_SET, SFAD_INT_SET,
    SFAD_ADD_IMM, SFAD_ADC_IMM, SFAD_ACC_ADD, SFAD_INC, SFAD_ADD_MEM, SFAD_SUB_REG,
    SFAD_ADC_TOMEM
  } sfad_op_e;

  typedef logic [5:0] sfad_clk_t;
endpackage : sfad_pkg

// File: test/sfad_decoder_checker.sv
// Checker for the decoder's operation classes, clock counts and busy window.
// Assumes it is bound to sfad_decoder and sees only its ports.
`timescale 1ns/1ns
module sfad_decoder_checker
  import sfad_pkg::*;
(
  // Clock and reset
  input wire logic                ref_clk_i,
  input wire logic                resetn_i,
  input wire logic                ce_i,
  // Mode and byte stream
  input wire logic                prot_mode_i,
  input wire logic                byte_valid_i,
  input wire logic [7:0]          byte_i,
  input wire logic                byte_ready_o,
  // Decoded operation
  input wire logic                op_start_o,
  input wire sfad_pkg::sfad_op_e  op_o,
  input wire logic                op_wide_o,
  input wire logic                op_mem_o,
  input wire sfad_pkg::sfad_clk_t op_clocks_o,
  input wire logic                busy_o,
  input wire logic                done_o,
  input wire logic                unknown_o
);
  import sfad_pkg::*;

  logic [7:0] tk1_reg;
  logic [7:0] tk1_next;
  logic [7:0] tk2_reg;
  logic [7:0] tk2_next;
  sfad_clk_t  cnt_reg;
  sfad_clk_t  cnt_next;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // ==========================================================
  // Last two taken bytes and busy-cycle count
  always_comb begin
    tk1_next = tk1_reg;
    tk2_next = tk2_reg;
    if (byte_valid_i && byte_ready_o && ce_i) begin
      tk1_next = byte_i;
      tk2_next = tk1_reg;
    end
    cnt_next = op_start_o ? {5'h0, ce_i} : cnt_reg + {5'h0, busy_o && ce_i};
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tk1_reg <= 8'h0;
      tk2_reg <= 8'h0;
      cnt_reg <= 6'h0;
    end else begin
      tk1_reg <= tk1_next;
      tk2_reg <= tk2_next;
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================
  // Properties
  property p_seg_std;
    op_start_o && $past(ce_i) && op_o inside {SFAD_LD_DATA, SFAD_LD_EXTRA, SFAD_LD_STACK}
      |-> op_clocks_o == ($past(prot_mode_i) ? 6'h16 : 6'h07);
  endproperty
  a_seg_std: assert property (p_seg_std) else $error("segment load count wrong");

  property p_seg_ext;
    op_start_o && $past(ce_i) && op_o inside {SFAD_LD_THIRD, SFAD_LD_FOURTH}
      |-> op_clocks_o == ($past(prot_mode_i) ? 6'h19 : 6'h07);
  endproperty
  a_seg_ext: assert property (p_seg_ext) else $error("extended segment load count wrong");

  property p_flag2;
    op_start_o && op_o inside {SFAD_CARRY_CLR, SFAD_DIR_CLR, SFAD_CARRY_INV, SFAD_FLAGS_TO_AH,
      SFAD_CARRY_SET, SFAD_DIR_SET} |-> op_clocks_o == 6'h02;
  endproperty
  a_flag2: assert property (p_flag2) else $error("flag op count wrong");

  property p_flag_misc;
    op_start_o && op_o inside {SFAD_INT_CLR, SFAD_INT_SET, SFAD_TS_CLR, SFAD_AH_TO_FLAGS}
      |-> op_clocks_o == (op_o == SFAD_TS_CLR ? 6'h06 : op_o == SFAD_AH_TO_FLAGS ? 6'h03 : 6'h08);
  endproperty
  a_flag_misc: assert property (p_flag_misc) else $error("long flag op count wrong");

  property p_arith_rm;
    op_start_o && op_o inside {SFAD_ADD_IMM, SFAD_ADC_IMM, SFAD_INC}
      |-> op_clocks_o == (!op_mem_o ? 6'h02 : op_o == SFAD_INC ? 6'h06 : 6'h07);
  endproperty
  a_arith_rm: assert property (p_arith_rm) else $error("reg or mem count wrong");

  property p_arith_fixed;
    op_start_o && op_o inside {SFAD_ACC_ADD, SFAD_ADD_MEM, SFAD_SUB_REG, SFAD_ADC_TOMEM}
      |-> op_clocks_o == (op_o == SFAD_ADD_MEM ? 6'h06 : op_o == SFAD_ADC_TOMEM ? 6'h07 : 6'h02);
  endproperty
  a_arith_fixed: assert property (p_arith_fixed) else $error("fixed add count wrong");

  // Width from first opcode byte, memory from the addressing byte
  property p_width;
    op_start_o && op_o inside {SFAD_ADD_IMM, SFAD_ADC_IMM, SFAD_INC}
      |-> op_wide_o == tk2_reg[0] && op_mem_o == (tk1_reg[7:6] != 2'h3);
  endproperty
  a_width: assert property (p_width) else $error("width or memory flag wrong");

  property p_done_len;
    done_o |-> (op_start_o ? 6'h01 : cnt_reg + 6'h01) == op_clocks_o;
  endproperty
  a_done_len: assert property (p_done_len) else $error("busy length differs from count");

  property p_start_busy;
    op_start_o |-> busy_o && !byte_ready_o && !unknown_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");

  c_third_prot: cover property (op_start_o && $past(prot_mode_i) && op_o == SFAD_LD_THIRD);
  c_long_done: cover property (done_o && op_clocks_o == 6'h19);
  c_inc_mem: cover property (op_start_o && op_mem_o && op_o == SFAD_INC);
endmodule : sfad_decoder_checker

bind sfad_decoder sfad_decoder_checker sfad_decoder_checker_i (.ref_clk_i, .resetn_i, .ce_i, .prot_mode_i,
  .byte_valid_i, .byte_i, .byte_ready_o, .op_start_o, .op_o, .op_wide_o, .op_mem_o, .op_clocks_o,
  .busy_o, .done_o, .unknown_o);

// File: test/testbench.sv
// Self-checking bench for the segment-load, flag and add decoder.
// Assumes sfad_pkg is compiled first; clock enable drops only in its own scenario.
`timescale 1ns/1ns
module testbench;
  import sfad_pkg::*;
  logic       ref_clk_i, resetn_i, ce_i, prot_mode_i, byte_valid_i;
  logic [7:0] byte_i;
  logic       byte_ready_o, op_start_o, op_wide_o, op_mem_o, busy_o, done_o, unknown_o;
  sfad_op_e   op_o;
  sfad_clk_t  op_clocks_o;
  int         fails, checks_done;

  sfad_decoder sfad_decoder_i (.ref_clk_i, .resetn_i, .ce_i, .prot_mode_i, .byte_valid_i, .byte_i,
    .byte_ready_o, .op_start_o, .op_o, .op_wide_o, .op_mem_o, .op_clocks_o, .busy_o, .done_o, .unknown_o);

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================
  // Shared tasks
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : chk

  // Holds the byte until ready is seen at a rising edge
  task send(input logic [7:0] b);
    int n;
    n = 0;
    byte_valid_i <= 1'b1;
    byte_i <= b;
    #1;
    while (byte_ready_o !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
      n++;
      if (n > 64) begin
        fails++;
        finish_test();
      end
    end
    @(posedge ref_clk_i);
  endtask : send

  task run_op(input logic [7:0] b0, b1, b2, input int nb, input logic prot, input sfad_op_e eop,
              input sfad_clk_t eclk, input logic emem);
    int cnt;
    int dn;
    prot_mode_i <= prot;
    send(b0);
    if (nb > 1) send(b1);
    if (nb > 2) send(b2);
    byte_valid_i <= 1'b0;
    #1;
    chk(op_start_o, 1'b1);
    chk(op_o, eop);
    chk(op_clocks_o, eclk);
    if (nb > 1 && b0 != 8'h0f) chk(op_mem_o, emem);
    if (b0 != 8'h0f) chk(op_wide_o, b0[0]);
    cnt = 0;
    dn = -1;
    while (busy_o === 1'b1 && cnt < 64) begin
      if (done_o === 1'b1) dn = cnt;
      @(posedge ref_clk_i);
      #1;
      cnt++;
    end
    chk(cnt, eclk);
    chk(dn, eclk - 6'h01);
    chk(byte_ready_o, 1'b1);
    @(posedge ref_clk_i);
  endtask : run_op

  // ==========================================================
  // Scenarios
  task t_seg;
    run_op(8'hc5, 8'h06, 8'h00, 2, 1'b0, SFAD_LD_DATA, 6'h07, 1'b1);
    run_op(8'hc5, 8'h06, 8'h00, 2, 1'b1, SFAD_LD_DATA, 6'h16, 1'b1);
    run_op(8'hc4, 8'h1e, 8'h00, 2, 1'b1, SFAD_LD_EXTRA, 6'h16, 1'b1);
    run_op(8'h0f, 8'hb4, 8'h07, 3, 1'b1, SFAD_LD_THIRD, 6'h19, 1'b1);
    run_op(8'h0f, 8'hb5, 8'h07, 3, 1'b0, SFAD_LD_FOURTH, 6'h07, 1'b1);
    run_op(8'h0f, 8'hb5, 8'h07, 3, 1'b1, SFAD_LD_FOURTH, 6'h19, 1'b1);
    run_op(8'h0f, 8'hb2, 8'h16, 3, 1'b1, SFAD_LD_STACK, 6'h16, 1'b1);
    $display("segment load test done");
  endtask : t_seg

  task t_flags;
    run_op(8'hf8, 8'h00, 8'h00, 1, 1'b0, SFAD_CARRY_CLR, 6'h02, 1'b0);
    run_op(8'hfc, 8'h00, 8'h00, 1, 1'b1, SFAD_DIR_CLR, 6'h02, 1'b0);
    run_op(8'hfa, 8'h00, 8'h00, 1, 1'b1, SFAD_INT_CLR, 6'h08, 1'b0);
    run_op(8'h0f, 8'h06, 8'h00, 2, 1'b1, SFAD_TS_CLR, 6'h06, 1'b0);
    run_op(8'hf5, 8'h00, 8'h00, 1, 1'b0, SFAD_CARRY_INV, 6'h02, 1'b0);
    run_op(8'h9f, 8'h00, 8'h00, 1, 1'b1, SFAD_FLAGS_TO_AH, 6'h02, 1'b0);
    run_op(8'h9e, 8'h00, 8'h00, 1, 1'b0, SFAD_AH_TO_FLAGS, 6'h03, 1'b0);
    run_op(8'hf9, 8'h00, 8'h00, 1, 1'b1, SFAD_CARRY_SET, 6'h02, 1'b0);
    run_op(8'hfd, 8'h00, 8'h00, 1, 1'b0, SFAD_DIR_SET, 6'h02, 1'b0);
    run_op(8'hfb, 8'h00, 8'h00, 1, 1'b0, SFAD_INT_SET, 6'h08, 1'b0);
    $display("flag test done");
  endtask : t_flags

  task t_arith;
    run_op(8'h80, 8'hc0, 8'h00, 2, 1'b0, SFAD_ADD_IMM, 6'h02, 1'b0);
    run_op(8'h81, 8'h05, 8'h00, 2, 1'b1, SFAD_ADD_IMM, 6'h07, 1'b1);
    run_op(8'h83, 8'hd1, 8'h00, 2, 1'b0, SFAD_ADC_IMM, 6'h02, 1'b0);
    run_op(8'h80, 8'h16, 8'h00, 2, 1'b1, SFAD_ADC_IMM, 6'h07, 1'b1);
    run_op(8'h04, 8'h00, 8'h00, 1, 1'b0, SFAD_ACC_ADD, 6'h02, 1'b0);
    run_op(8'h05, 8'h00, 8'h00, 1, 1'b1, SFAD_ACC_ADD, 6'h02, 1'b0);
    run_op(8'hfe, 8'hc0, 8'h00, 2, 1'b0, SFAD_INC, 6'h02, 1'b0);
    run_op(8'hff, 8'h00, 8'h00, 2, 1'b1, SFAD_INC, 6'h06, 1'b1);
    run_op(8'h03, 8'h47, 8'h00, 2, 1'b1, SFAD_ADD_MEM, 6'h06, 1'b1);
    run_op(8'h2b, 8'hd8, 8'h00, 2, 1'b0, SFAD_SUB_REG, 6'h02, 1'b0);
    run_op(8'h10, 8'h06, 8'h00, 2, 1'b1, SFAD_ADC_TOMEM, 6'h07, 1'b1);
    $display("arithmetic test done");
  endtask : t_arith

  // Field 001 of the immediate group is not an add
  task t_unknown;
    send(8'h80);
    send(8'hc8);
    byte_valid_i <= 1'b0;
    #1;
    chk(unknown_o, 1'b1);
    chk(busy_o, 1'b0);
    @(posedge ref_clk_i);
    run_op(8'hf8, 8'h00, 8'h00, 1, 1'b0, SFAD_CARRY_CLR, 6'h02, 1'b0);
    $display("unknown byte test done");
  endtask : t_unknown

  // Clock enable low freezes the count and the start pulse
  task t_ce;
    int cnt;
    cnt = 0;
    prot_mode_i <= 1'b0;
    send(8'hfa);
    byte_valid_i <= 1'b0;
    ce_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk(op_start_o, 1'b1);
    chk(busy_o, 1'b1);
    @(posedge ref_clk_i);
    ce_i <= 1'b1;
    #1;
    while (busy_o === 1'b1 && cnt < 64) begin
      @(posedge ref_clk_i);
      #1;
      cnt++;
    end
    chk(cnt, 8);
    chk(byte_ready_o, 1'b1);
    @(posedge ref_clk_i);
    $display("clock enable test done");
  endtask : t_ce

  // Reset in mid-operation drops busy at once
  task t_reset_mid;
    send(8'hfa);
    byte_valid_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    #1;
    chk(busy_o, 1'b0);
    chk(byte_ready_o, 1'b1);
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    run_op(8'hfb, 8'h00, 8'h00, 1, 1'b1, SFAD_INT_SET, 6'h08, 1'b0);
    $display("mid-run reset test done");
  endtask : t_reset_mid

  initial begin
    resetn_i = 1'b0;
    ce_i = 1'b1;
    prot_mode_i = 1'b0;
    byte_valid_i = 1'b0;
    byte_i = 8'h00;
    fails = 0;
    checks_done = 0;
    repeat (10) @(posedge ref_clk_i);
    #1;
    chk(byte_ready_o, 1'b1);
    chk(busy_o, 1'b0);
    chk(op_o, SFAD_NONE);
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    t_seg();
    t_flags();
    t_arith();
    t_unknown();
    t_ce();
    t_reset_mid();
    finish_test();
  end
endmodule : testbench
